// [logic/tbr_pkg.sv]
`default_nettype none

// ----------------------------------------------------------------------
// Shared constants of the bus buffer register
// ----------------------------------------------------------------------
package tbr_pkg;

   // Stored word width and register bus geometry.
   localparam int unsigned TBR_WIDTH      = 4;
   localparam int unsigned TBR_AXI_DATA_W = 32;
   localparam int unsigned TBR_AXI_ADDR_W = 8;
   localparam int unsigned TBR_CNT_W      = 16;

   // Register byte offsets.
   localparam logic [7:0] TBR_OFF_CTRL    = 8'h00;
   localparam logic [7:0] TBR_OFF_CMD     = 8'h04;
   localparam logic [7:0] TBR_OFF_SWDATA  = 8'h08;
   localparam logic [7:0] TBR_OFF_STATUS  = 8'h0c;
   localparam logic [7:0] TBR_OFF_EVENTS  = 8'h10;
   localparam logic [7:0] TBR_OFF_LOADCNT = 8'h14;

   // Field positions.
   localparam int unsigned TBR_CTRL_OUT_DIS_BIT = 0;
   localparam int unsigned TBR_CMD_CLEAR_BIT    = 0;
   localparam int unsigned TBR_CMD_LOAD_BIT     = 1;
   localparam int unsigned TBR_STAT_DRIVE_BIT   = 4;
   localparam int unsigned TBR_STAT_CLRPIN_BIT  = 5;
   localparam int unsigned TBR_EVT_LOAD_BIT     = 0;
   localparam int unsigned TBR_EVT_CLEAR_BIT    = 1;

   // Values after reset.
   localparam logic       TBR_RST_OUT_DIS = 1'h0;
   localparam logic [3:0] TBR_RST_SWDATA  = 4'h0;
   localparam logic [3:0] TBR_RST_STORED  = 4'h0;

   // Bus responses.
   localparam logic [1:0] TBR_RESP_OKAY   = 2'h0;
   localparam logic [1:0] TBR_RESP_SLVERR = 2'h2;

   // Bus channel state machines.
   typedef enum logic {
      TBR_WR_COLLECT,
      TBR_WR_RESP
   } tbr_wr_state_e;

   typedef enum logic {
      TBR_RD_IDLE,
      TBR_RD_RESP
   } tbr_rd_state_e;

endpackage

`default_nettype wire

// [logic/tbr_core.sv]
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------------
// Four-bit storage cell with gated load, clear and output control
// ----------------------------------------------------------------------
module tbr_core #(
   parameter int unsigned W = tbr_pkg::TBR_WIDTH
) (
   // Clock and reset
   input  wire logic         aclk,
   input  wire logic         aresetn,
   // Load and clear
   input  wire logic [W-1:0] data,
   input  wire logic         load_a_n,
   input  wire logic         load_b_n,
   input  wire logic         alt_load,
   input  wire logic [W-1:0] alt_data,
   input  wire logic         clear,
   // Output control
   input  wire logic         oc_m_n,
   input  wire logic         oc_n_n,
   // Stored value and pin drive
   output logic     [W-1:0]  stored,
   output logic     [W-1:0]  pin_q,
   output logic     [W-1:0]  pin_oe,
   output logic              driving
);

   generate
      if (W < 1) begin : g_bad_width
         $error("tbr_core width must be at least one");
      end
   endgenerate

   typedef struct packed {
      logic [W-1:0] stored;
      logic         drive;
   } tbr_core_s;

   tbr_core_s st_r;
   tbr_core_s st_nxt;

   // Next state; the output control never reaches the storage path.
   always_comb begin
      st_nxt = st_r;
      if (clear) begin
         st_nxt.stored = '0;
      end else if (!load_a_n && !load_b_n) begin
         st_nxt.stored = data;
      end else if (alt_load) begin
         st_nxt.stored = alt_data;
      end
      st_nxt.drive = !oc_m_n && !oc_n_n;
   end

   // State register.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r <= '{stored: W'(tbr_pkg::TBR_RST_STORED), drive: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign stored  = st_r.stored;
   assign pin_q   = st_r.stored;
   assign pin_oe  = {W{st_r.drive}};
   assign driving = st_r.drive;

endmodule

`default_nettype wire

// [logic/tbr_top.sv]
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------------
// Bus buffer register with register access over AXI4-Lite
// ----------------------------------------------------------------------

// What this block does
// - Holds a four-bit word in flip-flops, one input and three-state output each.
// - Loads inputs at a clock edge only when both load enables are low.
// - Drives stored levels on all outputs only while both output controls are low.
// - Either output control high floats all outputs from the next clock edge on.
// - Loading, holding and clearing continue unchanged while outputs float.
module tbr_top #(
   parameter int unsigned W      = tbr_pkg::TBR_WIDTH,
   parameter int unsigned ADDR_W = tbr_pkg::TBR_AXI_ADDR_W,
   parameter int unsigned DATA_W = tbr_pkg::TBR_AXI_DATA_W,
   parameter int unsigned CNT_W  = tbr_pkg::TBR_CNT_W
) (
   // Clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // Write address channel
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic [2:0]        s_axi_awprot,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   // Write data channel
   input  wire logic [DATA_W-1:0] s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   // Write response channel
   output logic     [1:0]         s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // Read address channel
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic [2:0]        s_axi_arprot,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   // Read data channel
   output logic     [DATA_W-1:0]  s_axi_rdata,
   output logic     [1:0]         s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // Parallel data and load enables
   input  wire logic [W-1:0]      data_in,
   input  wire logic              load_enable_a_n,
   input  wire logic              load_enable_b_n,
   input  wire logic              clear,
   // Output controls
   input  wire logic              output_control_m_n,
   input  wire logic              output_control_n_n,
   // Three-state bus outputs
   output logic     [W-1:0]       q_out,
   output logic     [W-1:0]       q_oe
);

   // ----------------------------------------------------------------------
   // Parameter checks
   // ----------------------------------------------------------------------
   generate
      if (DATA_W != 32) begin : g_bad_data
         $error("tbr_top supports 32-bit bus data only");
      end
      if (ADDR_W < 5 || ADDR_W > 8) begin : g_bad_addr
         $error("tbr_top address width must lie between 5 and 8");
      end
      if (W < 1 || W > 4) begin : g_bad_width
         $error("tbr_top word width must lie between 1 and 4");
      end
      if (CNT_W < 1 || CNT_W > 32) begin : g_bad_cnt
         $error("tbr_top counter width must lie between 1 and 32");
      end
   endgenerate

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   typedef struct packed {
      tbr_pkg::tbr_wr_state_e wr_st;
      logic                   aw_have;
      logic                   w_have;
      logic [ADDR_W-1:0]      awaddr;
      logic [DATA_W-1:0]      wdata;
      logic [3:0]             wstrb;
      logic                   awready;
      logic                   wready;
      logic                   bvalid;
      logic [1:0]             bresp;
      tbr_pkg::tbr_rd_state_e rd_st;
      logic                   arready;
      logic                   rvalid;
      logic [1:0]             rresp;
      logic [DATA_W-1:0]      rdata;
      logic                   out_dis;
      logic [W-1:0]           sw_data;
      logic                   sw_clear;
      logic                   sw_load;
      logic                   ev_load;
      logic                   ev_clear;
      logic [CNT_W-1:0]       load_cnt;
   } tbr_top_s;

   tbr_top_s st_r;
   tbr_top_s st_nxt;

   logic [W-1:0] core_stored;
   logic         core_driving;
   logic         clear_any;
   logic         pin_load;
   logic         load_evt;

   // ----------------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------------

   // True for an offset that holds a register.
   function automatic logic tbr_mapped(input logic [ADDR_W-1:0] addr);
      logic [7:0] a;
      a = 8'(addr);
      tbr_mapped = (a == tbr_pkg::TBR_OFF_CTRL)   || (a == tbr_pkg::TBR_OFF_CMD)    ||
                   (a == tbr_pkg::TBR_OFF_SWDATA) || (a == tbr_pkg::TBR_OFF_STATUS) ||
                   (a == tbr_pkg::TBR_OFF_EVENTS) || (a == tbr_pkg::TBR_OFF_LOADCNT);
   endfunction

   // Register offset with the bus address zero-extended to a byte.
   function automatic logic [7:0] tbr_off(input logic [ADDR_W-1:0] addr);
      tbr_off = 8'(addr);
   endfunction

   // ----------------------------------------------------------------------
   // Storage cell
   // ----------------------------------------------------------------------

   // Software clear joins the pin clear; both share the one priority path.
   assign clear_any = clear || st_r.sw_clear;
   assign pin_load  = !load_enable_a_n && !load_enable_b_n;
   assign load_evt  = !clear_any && (pin_load || st_r.sw_load);

   tbr_core #(
      .W (W)
   ) u_core (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .data     (data_in),
      .load_a_n (load_enable_a_n),
      .load_b_n (load_enable_b_n),
      .alt_load (st_r.sw_load),
      .alt_data (st_r.sw_data),
      .clear    (clear_any),
      .oc_m_n   (output_control_m_n || st_r.out_dis),
      .oc_n_n   (output_control_n_n),
      .stored   (core_stored),
      .pin_q    (q_out),
      .pin_oe   (q_oe),
      .driving  (core_driving)
   );

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb begin
      logic              aw_h;
      logic              w_h;
      logic [ADDR_W-1:0] waddr;
      logic [DATA_W-1:0] wdat;
      logic [3:0]        wstb;
      logic [7:0]        roff;
      logic              ev_load_clr;
      logic              ev_clear_clr;
      aw_h         = st_r.aw_have;
      w_h          = st_r.w_have;
      waddr        = st_r.awaddr;
      wdat         = st_r.wdata;
      wstb         = st_r.wstrb;
      roff         = tbr_off(s_axi_araddr);
      ev_load_clr  = 1'b0;
      ev_clear_clr = 1'b0;
      st_nxt       = st_r;

      // Command bits are single-cycle strobes.
      st_nxt.sw_clear = 1'b0;
      st_nxt.sw_load  = 1'b0;

      // Write channel: address and data are taken in either order.
      case (st_r.wr_st)
         tbr_pkg::TBR_WR_COLLECT: begin
            if (s_axi_awvalid && st_r.awready) begin
               aw_h  = 1'b1;
               waddr = s_axi_awaddr;
            end
            if (s_axi_wvalid && st_r.wready) begin
               w_h  = 1'b1;
               wdat = s_axi_wdata;
               wstb = s_axi_wstrb;
            end
            st_nxt.aw_have = aw_h;
            st_nxt.w_have  = w_h;
            st_nxt.awaddr  = waddr;
            st_nxt.wdata   = wdat;
            st_nxt.wstrb   = wstb;
            if (aw_h && w_h) begin
               st_nxt.wr_st  = tbr_pkg::TBR_WR_RESP;
               st_nxt.bvalid = 1'b1;
               st_nxt.bresp  = tbr_mapped(waddr) ? tbr_pkg::TBR_RESP_OKAY
                                                 : tbr_pkg::TBR_RESP_SLVERR;
               // Only the low byte carries fields; without its strobe nothing moves.
               if (wstb[0]) begin
                  if (tbr_off(waddr) == tbr_pkg::TBR_OFF_CTRL) begin
                     st_nxt.out_dis = wdat[tbr_pkg::TBR_CTRL_OUT_DIS_BIT];
                  end else if (tbr_off(waddr) == tbr_pkg::TBR_OFF_CMD) begin
                     st_nxt.sw_clear = wdat[tbr_pkg::TBR_CMD_CLEAR_BIT];
                     st_nxt.sw_load  = wdat[tbr_pkg::TBR_CMD_LOAD_BIT];
                  end else if (tbr_off(waddr) == tbr_pkg::TBR_OFF_SWDATA) begin
                     st_nxt.sw_data = wdat[W-1:0];
                  end else if (tbr_off(waddr) == tbr_pkg::TBR_OFF_EVENTS) begin
                     ev_load_clr  = wdat[tbr_pkg::TBR_EVT_LOAD_BIT];
                     ev_clear_clr = wdat[tbr_pkg::TBR_EVT_CLEAR_BIT];
                  end
               end
            end
         end
         tbr_pkg::TBR_WR_RESP: begin
            if (s_axi_bready) begin
               st_nxt.wr_st   = tbr_pkg::TBR_WR_COLLECT;
               st_nxt.bvalid  = 1'b0;
               st_nxt.aw_have = 1'b0;
               st_nxt.w_have  = 1'b0;
            end
         end
         default: begin
            st_nxt.wr_st = tbr_pkg::TBR_WR_COLLECT;
         end
      endcase

      // Ready only while the matching half is still missing.
      st_nxt.awready = (st_nxt.wr_st == tbr_pkg::TBR_WR_COLLECT) && !st_nxt.aw_have;
      st_nxt.wready  = (st_nxt.wr_st == tbr_pkg::TBR_WR_COLLECT) && !st_nxt.w_have;

      // Read channel: data are sampled at the edge that takes the address.
      case (st_r.rd_st)
         tbr_pkg::TBR_RD_IDLE: begin
            if (s_axi_arvalid && st_r.arready) begin
               st_nxt.rd_st  = tbr_pkg::TBR_RD_RESP;
               st_nxt.rvalid = 1'b1;
               st_nxt.rresp  = tbr_mapped(s_axi_araddr) ? tbr_pkg::TBR_RESP_OKAY
                                                        : tbr_pkg::TBR_RESP_SLVERR;
               st_nxt.rdata  = '0;
               if (roff == tbr_pkg::TBR_OFF_CTRL) begin
                  st_nxt.rdata[tbr_pkg::TBR_CTRL_OUT_DIS_BIT] = st_r.out_dis;
               end else if (roff == tbr_pkg::TBR_OFF_SWDATA) begin
                  st_nxt.rdata[W-1:0] = st_r.sw_data;
               end else if (roff == tbr_pkg::TBR_OFF_STATUS) begin
                  st_nxt.rdata[W-1:0]                         = core_stored;
                  st_nxt.rdata[tbr_pkg::TBR_STAT_DRIVE_BIT]  = core_driving;
                  st_nxt.rdata[tbr_pkg::TBR_STAT_CLRPIN_BIT] = clear;
               end else if (roff == tbr_pkg::TBR_OFF_EVENTS) begin
                  st_nxt.rdata[tbr_pkg::TBR_EVT_LOAD_BIT]  = st_r.ev_load;
                  st_nxt.rdata[tbr_pkg::TBR_EVT_CLEAR_BIT] = st_r.ev_clear;
               end else if (roff == tbr_pkg::TBR_OFF_LOADCNT) begin
                  st_nxt.rdata[CNT_W-1:0] = st_r.load_cnt;
               end
            end
         end
         tbr_pkg::TBR_RD_RESP: begin
            if (s_axi_rready) begin
               st_nxt.rd_st  = tbr_pkg::TBR_RD_IDLE;
               st_nxt.rvalid = 1'b0;
            end
         end
         default: begin
            st_nxt.rd_st = tbr_pkg::TBR_RD_IDLE;
         end
      endcase
      st_nxt.arready = (st_nxt.rd_st == tbr_pkg::TBR_RD_IDLE);

      // Sticky events; a new event in the clearing cycle survives the clear.
      st_nxt.ev_load  = (st_r.ev_load && !ev_load_clr) || load_evt;
      st_nxt.ev_clear = (st_r.ev_clear && !ev_clear_clr) || clear_any;

      // The count wraps; software reads differences, so wrap costs nothing.
      if (load_evt) begin
         st_nxt.load_cnt = st_r.load_cnt + CNT_W'(1);
      end
   end

   // ----------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r          <= '0;
         st_r.wr_st    <= tbr_pkg::TBR_WR_COLLECT;
         st_r.rd_st    <= tbr_pkg::TBR_RD_IDLE;
         st_r.out_dis  <= tbr_pkg::TBR_RST_OUT_DIS;
         st_r.sw_data  <= W'(tbr_pkg::TBR_RST_SWDATA);
         st_r.bresp    <= tbr_pkg::TBR_RESP_OKAY;
         st_r.rresp    <= tbr_pkg::TBR_RESP_OKAY;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // Bus outputs
   // ----------------------------------------------------------------------

   // Every bus output is a field of the state register.
   assign s_axi_awready = st_r.awready;
   assign s_axi_wready  = st_r.wready;
   assign s_axi_bvalid  = st_r.bvalid;
   assign s_axi_bresp   = st_r.bresp;
   assign s_axi_arready = st_r.arready;
   assign s_axi_rvalid  = st_r.rvalid;
   assign s_axi_rresp   = st_r.rresp;
   assign s_axi_rdata   = st_r.rdata;

endmodule

`default_nettype wire

// [verification/tbr_bus_model.sv]
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------------
// Shared parallel bus with one other talker
// ----------------------------------------------------------------------
module tbr_bus_model #(
   parameter int unsigned W = 4
) (
   // Clock
   input  wire logic         aclk,
   // Register side
   input  wire logic [W-1:0] q_out,
   input  wire logic [W-1:0] q_oe,
   // Other talker
   input  wire logic [W-1:0] peer_d,
   input  wire logic         peer_oe,
   // Resolved lines
   output logic     [W-1:0]  bus_lvl,
   output logic              clash
);
   logic [W-1:0] last_r = '0;

   // The bus has no pull-ups, so a released line shows the inverse of its
   // last level; a stale value can then never pass for a driven one.
   always_comb begin
      for (int i = 0; i < W; i++) begin
         if (q_oe[i])
            bus_lvl[i] = q_out[i];
         else if (peer_oe)
            bus_lvl[i] = peer_d[i];
         else
            bus_lvl[i] = ~last_r[i];
      end
      clash = peer_oe && (q_oe != '0);
   end

   // Remember the level seen on each line.
   always_ff @(posedge aclk) begin
      last_r <= bus_lvl;
   end
endmodule

`default_nettype wire

// [verification/tbr_top_asserts.sv]
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------------
// Port checks of the bus buffer register
// ----------------------------------------------------------------------
module tbr_top_asserts #(
   parameter int unsigned W = 4
) (
   // Clock and reset
   input  wire logic         aclk,
   input  wire logic         aresetn,
   // Watched pins
   input  wire logic         s_axi_bvalid,
   input  wire logic [W-1:0] data_in,
   input  wire logic         load_enable_a_n,
   input  wire logic         load_enable_b_n,
   input  wire logic         clear,
   input  wire logic         output_control_m_n,
   input  wire logic         output_control_n_n,
   input  wire logic [W-1:0] q_out,
   input  wire logic [W-1:0] q_oe
);
   logic [1:0] live_r;
   logic [1:0] live_nxt;

   // Count two edges out of reset, so no check looks back into reset.
   always_comb begin
      live_nxt = (live_r == 2'h2) ? live_r : live_r + 2'h1;
   end
   always_ff @(posedge aclk) begin
      live_r <= aresetn ? live_nxt : 2'h0;
   end

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // A register command acts in the first answer cycle, so that cycle is left out.
   sequence s_pin_load;
      live_r == 2'h2 && !clear && !load_enable_a_n && !load_enable_b_n
         && !$rose(s_axi_bvalid);
   endsequence
   sequence s_floated;
      output_control_m_n || output_control_n_n;
   endsequence

   a_load_taken: assert property (s_pin_load |=> q_out == $past(data_in))
      else $error("stored word differs from data at an enabled edge");
   a_hold_gated: assert property (live_r == 2'h2 && !clear
      && (load_enable_a_n || load_enable_b_n) && !$rose(s_axi_bvalid) |=> $stable(q_out))
      else $error("stored word changed with a load enable high");
   a_float_loads: assert property (s_floated ##0 s_pin_load
      |=> q_oe == '0 && q_out == $past(data_in))
      else $error("load lost while outputs float");
   a_clear_zero: assert property (clear |=> q_out == '0)
      else $error("clear did not zero the word");
   a_clear_held: assert property (clear [*3] |-> q_out == '0)
      else $error("word left zero while clear held");
   a_drive_both: assert property (q_oe != '0 |-> q_oe == '1
      && $past(output_control_m_n) == 1'b0 && $past(output_control_n_n) == 1'b0)
      else $error("outputs driven without both controls low");
   a_float_either: assert property (s_floated |=> q_oe == '0)
      else $error("outputs driven with a control high");
   a_width_whole: assert property (q_oe == '0 || q_oe == '1)
      else $error("output enables split across bits");
endmodule

bind tbr_top tbr_top_asserts #(.W(W)) u_tbr_chk (
   .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid), .data_in(data_in),
   .load_enable_a_n(load_enable_a_n), .load_enable_b_n(load_enable_b_n), .clear(clear),
   .output_control_m_n(output_control_m_n), .output_control_n_n(output_control_n_n),
   .q_out(q_out), .q_oe(q_oe)
);

`default_nettype wire

// [verification/tristate_bus_register_4bit_tb.sv]
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------------
// Self-checking bench of the bus buffer register
// ----------------------------------------------------------------------
module tristate_bus_register_4bit_tb;
   logic        aclk = 1'b0, aresetn = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, clash;
   logic [1:0]  bresp, rresp, resp;
   logic [31:0] rdata, rd;
   logic [3:0]  data_in = 4'h0, q_out, q_oe, bus_lvl;
   logic        lea_n = 1'b1, leb_n = 1'b1, clr = 1'b0, ocm_n = 1'b1, ocn_n = 1'b1;
   logic [3:0]  peer_d = 4'h5;
   logic        peer_oe = 1'b0;
   int          err_total = 0, comparisons = 0;
   logic [7:0]  reg_off [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};

   always #20 aclk = ~aclk;

   tbr_top uut (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .data_in(data_in), .load_enable_a_n(lea_n),
      .load_enable_b_n(leb_n), .clear(clr), .output_control_m_n(ocm_n),
      .output_control_n_n(ocn_n), .q_out(q_out), .q_oe(q_oe)
   );

   tbr_bus_model #(.W(4)) u_bus (
      .aclk(aclk), .q_out(q_out), .q_oe(q_oe), .peer_d(peer_d), .peer_oe(peer_oe),
      .bus_lvl(bus_lvl), .clash(clash)
   );

   // ----------------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------------
   task automatic conclude();
      $display("comparisons=%0d err_total=%0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Hold each channel until its own handshake edge; a spent bound ends the run.
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int   n;
      logic done;
      n = 0;
      done = 1'b0;
      r = 2'h3;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!done && n < 50) begin
         @(posedge aclk);
         n++;
         if (awvalid && awready)
            awvalid <= 1'b0;
         if (wvalid && wready)
            wvalid <= 1'b0;
         if (bvalid && bready) begin
            done = 1'b1;
            r = bresp;
            bready <= 1'b0;
         end
      end
      if (!done) begin
         err_total++;
         conclude();
      end
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int   n;
      logic done;
      n = 0;
      done = 1'b0;
      d = 'x;
      r = 2'h3;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!done && n < 50) begin
         @(posedge aclk);
         n++;
         if (arvalid && arready)
            arvalid <= 1'b0;
         if (rvalid && rready) begin
            done = 1'b1;
            d = rdata;
            r = rresp;
            rready <= 1'b0;
         end
      end
      if (!done) begin
         err_total++;
         conclude();
      end
   endtask

   task automatic tick();
      @(posedge aclk);
      #1;
   endtask

   // inputs settle a cycle before the capture edge.
   task automatic pins(input logic [3:0] d, input logic ea, input logic eb,
                       input logic cl, input logic om, input logic on);
      @(posedge aclk);
      data_in <= d;
      lea_n <= ea;
      leb_n <= eb;
      clr <= cl;
      ocm_n <= om;
      ocn_n <= on;
      peer_oe <= om | on;
      tick();
   endtask

   // ----------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      // Every register reads zero after reset; an unmapped place is refused.
      foreach (reg_off[i]) begin
         axi_rd(reg_off[i], rd, resp);
         chk(rd, 32'h0);
         chk(resp, 32'h0);
      end
      axi_rd(8'h18, rd, resp);
      chk(rd, 32'h0);
      chk(resp, 32'h2);
      axi_wr(8'h18, 32'h1, resp);
      chk(resp, 32'h2);
      // Load while floating, then every enable pair; only both low loads.
      pins(4'h9, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
      chk(q_out, 32'h9);
      for (int k = 3; k >= 0; k--) begin
         pins(4'h6, k[0], k[1], 1'b0, 1'b1, 1'b1);
         chk(q_out, (k == 0) ? 32'h6 : 32'h9);
         chk(q_oe, 32'h0);
         chk(bus_lvl, 32'h5);
      end
      // Clear beats a load and holds across edges, outputs floating.
      repeat (2) begin
         pins(4'ha, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
         chk(q_out, 32'h0);
      end
      // Every output control pair; only both low drives the lines.
      for (int k = 3; k >= 0; k--) begin
         pins(4'ha, 1'b0, 1'b0, 1'b0, k[0], k[1]);
         chk(q_oe, (k == 0) ? 32'hf : 32'h0);
         chk(bus_lvl, (k == 0) ? 32'ha : 32'h5);
         chk(clash, 32'h0);
      end
      // Register-driven load and clear with a pin enable high.
      axi_wr(8'h08, 32'hffff_fffc, resp);
      chk(resp, 32'h0);
      axi_rd(8'h08, rd, resp);
      chk(rd, 32'hc);
      pins(4'h3, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
      chk(q_out, 32'ha);
      axi_wr(8'h04, 32'h2, resp);
      tick();
      chk(q_out, 32'hc);
      axi_rd(8'h0c, rd, resp);
      chk(rd, 32'h1c);
      axi_wr(8'h00, 32'h1, resp);
      tick();
      chk(q_oe, 32'h0);
      axi_wr(8'h00, 32'h0, resp);
      axi_wr(8'h04, 32'h1, resp);
      tick();
      chk(q_out, 32'h0);
      chk(q_oe, 32'hf);
      axi_rd(8'h10, rd, resp);
      chk(rd, 32'h3);
      axi_wr(8'h10, 32'h3, resp);
      axi_rd(8'h10, rd, resp);
      chk(rd, 32'h0);
      // A second reset drops word and drive; loading resumes after it.
      @(posedge aclk);
      aresetn <= 1'b0;
      pins(4'h7, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      chk(q_out, 32'h0);
      chk(q_oe, 32'h0);
      @(posedge aclk);
      aresetn <= 1'b1;
      pins(4'h7, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      chk(q_out, 32'h7);
      chk(q_oe, 32'hf);
      // Enables stay low, so the count holds the loads since reset up to the read edge.
      axi_rd(8'h14, rd, resp);
      chk(rd, 32'h3);
      conclude();
   end
endmodule

`default_nettype wire
